// >>> rtl/hv_pkg.sv
package hv_pkg;
  // -------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int WAKE_FILT_US   = 16;
  localparam int WAKE_FILT_CYC  = WAKE_FILT_US * CLK_MHZ;
  localparam int WAKE_BLANK_US  = 30;
  localparam int WAKE_BLANK_CYC = WAKE_BLANK_US * CLK_MHZ;
  localparam int OC_FILT_US     = 26;
  localparam int OC_FILT_CYC    = OC_FILT_US * CLK_MHZ;
  localparam int OL_FILT_US     = 64;
  localparam int OL_FILT_CYC    = OL_FILT_US * CLK_MHZ;
  // -------------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_MODE  = 8'h04;
  localparam logic [7:0]  ADDR_STAT  = 8'h08;
  localparam logic [7:0]  ADDR_CLR   = 8'h0C;
  localparam logic [7:0]  ADDR_EN    = 8'h10;
  localparam logic [7:0]  ADDR_LVL   = 8'h14;
  localparam int          CTRL_FUNC  = 0;
  localparam int          CTRL_MEAS  = 3;
  localparam int          CTRL_TEST  = 4;
  localparam int          CTRL_PULL  = 5;
  localparam int          CTRL_OTHWK = 7;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [1:0]  PULL_RST   = 2'h0;
  localparam int          PULL_DN    = 0;
  localparam int          PULL_UP    = 1;
  // -------------------------------------------------------------------
  // Pin function codes and modes
  // -------------------------------------------------------------------
  localparam logic [2:0] FUNC_FO   = 3'h0;
  localparam logic [2:0] FUNC_HSCS = 3'h3;
  localparam logic [2:0] FUNC_OFF  = 3'h4;
  localparam logic [2:0] FUNC_WAKE = 3'h5;
  localparam logic [2:0] FUNC_LS   = 3'h6;
  localparam logic [2:0] FUNC_HS   = 3'h7;
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_STOP   = 2'h1;
  localparam logic [1:0] REQ_SLEEP  = 2'h2;
  typedef enum logic [2:0] {M_NORMAL, M_STOP, M_SLEEP, M_RESTART, M_FAILSAFE} sbc_mode_t;
  // -------------------------------------------------------------------
  // Event bits
  // -------------------------------------------------------------------
  localparam int EV_WAKE = 0;
  localparam int EV_OC   = 1;
  localparam int EV_OL   = 2;
  localparam int EV_ERR  = 3;
  localparam int EV_W    = 4;
endpackage

// >>> rtl/irq_if.sv
`timescale 1ns/1ns
`default_nettype none
// Carries event sets, clears and enables between the core and the event block.
interface irq_if;
  logic [hv_pkg::EV_W-1:0] set;
  logic [hv_pkg::EV_W-1:0] clr;
  logic [hv_pkg::EV_W-1:0] en_wdata;
  logic                    en_we;
  logic [hv_pkg::EV_W-1:0] status;
  logic [hv_pkg::EV_W-1:0] en;
  logic                    irq;
  modport ctl (output set, clr, en_wdata, en_we, input status, en, irq);
  modport blk (input set, clr, en_wdata, en_we, output status, en, irq);
endinterface
`default_nettype wire

// >>> rtl/persist_filter.sv
`timescale 1ns/1ns
`default_nettype none
module persist_filter #(
  parameter int N = 2
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic cond,
  output logic      hit
);
  localparam int W = $clog2(N + 1);
  logic [W-1:0] cnt_r;

  // Counts consecutive cycles of the condition; any gap restarts the count.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (!cond) begin
      cnt_r <= '0;
    end else if (!hit) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Qualified once the condition has stood for N cycles.
  assign hit = cond && (cnt_r == W'(N - 1));

  a_no_early_hit: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(cond) |-> !hit)
    else $error("persistence filter fired on the first cycle of a condition");
endmodule
`default_nettype wire

// >>> rtl/irq_events.sv
`timescale 1ns/1ns
`default_nettype none
module irq_events (
  input  wire logic mclk,
  input  wire logic rst_b,
  irq_if.blk        bus
);
  // Sticky status: a set in the same cycle as a clear wins.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bus.status <= '0;
    end else begin
      bus.status <= (bus.status & ~bus.clr) | bus.set;
    end
  end

  // Enable register.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bus.en <= '0;
    end else if (bus.en_we) begin
      bus.en <= bus.en_wdata;
    end
  end

  assign bus.irq = |(bus.status & bus.en);

  a_set_wins: assert property (@(posedge mclk) disable iff (!rst_b)
    |bus.set |=> ((bus.status & $past(bus.set)) == $past(bus.set)))
    else $error("event set lost against a clear");
endmodule
`default_nettype wire

// >>> rtl/hv_pin_measure_interlock.sv
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module hv_pin_measure_interlock #(
  parameter int OL_FILT_CYC = hv_pkg::OL_FILT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hv_wake_pin,
  input  wire logic        overcurrent_det,
  input  wire logic        open_load_det,
  input  wire logic        fail_safe_req,
  output logic             irq,
  output logic             interrupt_out_n,
  output logic             fail_output_on,
  output logic             ls_switch_on,
  output logic             hs_switch_on,
  output logic             pull_up_en,
  output logic             pull_down_en,
  output logic             measure_route_en,
  output logic [2:0]       sbc_mode
);
  // -------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------
  localparam int BW = $clog2(hv_pkg::WAKE_BLANK_CYC + 1);
  hv_pkg::sbc_mode_t mode_r;
  hv_pkg::sbc_mode_t mode_nxt;
  logic [3:0]    sync1_r;
  logic [3:0]    sync2_r;
  logic [2:0]    func_r;
  logic          meas_r;
  logic          test_r;
  logic [1:0]    pull_r;
  logic          oth_r;
  logic          wake_lvl_r;
  logic          wake_en;
  logic          wake_en_q_r;
  logic [BW-1:0] blank_cnt_r;
  logic          wake_hit;
  logic          wake_edge;
  logic          oc_hit;
  logic          ol_hit;
  logic          sw_func;
  logic          wr;
  logic          wr_ctrl;
  logic          wr_mode;
  logic          sleep_refused;
  logic          err_ev;
  logic [2:0]    new_func;
  logic          mapped;
  logic          outage_entry;
  irq_if         ev ();

  // -------------------------------------------------------------------
  // APB slave
  // -------------------------------------------------------------------
  // Zero wait states: the access phase always completes.
  assign pready   = penable;
  assign wr       = psel && penable && pwrite;
  assign wr_ctrl  = wr && (paddr == hv_pkg::ADDR_CTRL);
  assign wr_mode  = wr && (paddr == hv_pkg::ADDR_MODE);
  assign new_func = pwdata[hv_pkg::CTRL_FUNC +: 3];
  assign mapped   = (paddr == hv_pkg::ADDR_CTRL) || (paddr == hv_pkg::ADDR_MODE) ||
                    (paddr == hv_pkg::ADDR_STAT) || (paddr == hv_pkg::ADDR_CLR) ||
                    (paddr == hv_pkg::ADDR_EN) || (paddr == hv_pkg::ADDR_LVL);
  assign pslverr  = psel && penable && !mapped;

  // Read data is captured in the setup cycle and held through the access phase.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      unique case (paddr)
        hv_pkg::ADDR_CTRL: prdata <= {24'h00_0000, oth_r, pull_r, test_r, meas_r, func_r};
        hv_pkg::ADDR_MODE: prdata <= {29'h0000_0000, mode_r};
        hv_pkg::ADDR_STAT: prdata <= {28'h000_0000, ev.status};
        hv_pkg::ADDR_EN:   prdata <= {28'h000_0000, ev.en};
        hv_pkg::ADDR_LVL:  prdata <= {31'h0000_0000, wake_lvl_r};
        default:           prdata <= '0;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------
  // Pin-side comparator and detector levels pass two flip-flops.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {fail_safe_req, open_load_det, overcurrent_det, hv_wake_pin};
      sync2_r <= sync1_r;
    end
  end

  // -------------------------------------------------------------------
  // Configuration register
  // -------------------------------------------------------------------
  assign sw_func = (func_r == hv_pkg::FUNC_LS) || (func_r == hv_pkg::FUNC_HS) ||
                   (func_r == hv_pkg::FUNC_HSCS);
  assign outage_entry = (mode_nxt == hv_pkg::M_RESTART || mode_nxt == hv_pkg::M_FAILSAFE) &&
                        !(mode_r == hv_pkg::M_RESTART || mode_r == hv_pkg::M_FAILSAFE);

  // Pin function: shutdown forces Off; frozen while sensing is on.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      func_r <= hv_pkg::CTRL_RST[hv_pkg::CTRL_FUNC +: 3];
    end else if (oc_hit || (outage_entry && sw_func)) begin
      func_r <= hv_pkg::FUNC_OFF;
    end else if (wr_ctrl && !meas_r) begin
      func_r <= new_func;
    end
  end

  // Sensing enable; refused when the resulting function is fail output.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meas_r <= hv_pkg::CTRL_RST[hv_pkg::CTRL_MEAS];
    end else if (wr_ctrl) begin
      meas_r <= pwdata[hv_pkg::CTRL_MEAS] && (meas_r || new_func != hv_pkg::FUNC_FO);
    end
  end

  // Fail output test trigger is unavailable while sensing.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      test_r <= hv_pkg::CTRL_RST[hv_pkg::CTRL_TEST];
    end else if (meas_r) begin
      test_r <= 1'b0;
    end else if (wr_ctrl) begin
      test_r <= pwdata[hv_pkg::CTRL_TEST];
    end
  end

  // Pull setting and other-wake-source flag are always stored.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pull_r <= hv_pkg::PULL_RST;
      oth_r  <= hv_pkg::CTRL_RST[hv_pkg::CTRL_OTHWK];
    end else if (wr_ctrl) begin
      pull_r <= pwdata[hv_pkg::CTRL_PULL +: 2];
      oth_r  <= pwdata[hv_pkg::CTRL_OTHWK];
    end
  end

  // Refused enable attempts and refused sensing set raise the error event.
  always_comb begin
    err_ev = sleep_refused;
    if (wr_ctrl && meas_r && new_func != hv_pkg::FUNC_OFF && new_func != func_r) begin
      err_ev = 1'b1;
    end
    if (wr_ctrl && meas_r && pwdata[hv_pkg::CTRL_TEST]) begin
      err_ev = 1'b1;
    end
    if (wr_ctrl && !meas_r && pwdata[hv_pkg::CTRL_MEAS] && new_func == hv_pkg::FUNC_FO) begin
      err_ev = 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // Wake input path
  // -------------------------------------------------------------------
  // Sensing gates the internal wake signal entirely.
  assign wake_en = (func_r == hv_pkg::FUNC_WAKE) && !meas_r;

  // Blanking starts each time the wake input becomes enabled.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wake_en_q_r <= 1'b0;
      blank_cnt_r <= '0;
    end else begin
      wake_en_q_r <= wake_en;
      if (wake_en && !wake_en_q_r) begin
        blank_cnt_r <= BW'(hv_pkg::WAKE_BLANK_CYC);
      end else if (blank_cnt_r != '0) begin
        blank_cnt_r <= blank_cnt_r - 1'b1;
      end
    end
  end

  persist_filter #(.N(hv_pkg::WAKE_FILT_CYC)) u_wake_filt (
    .mclk  (mclk),
    .rst_b (rst_b),
    .cond  (wake_en && (sync2_r[0] != wake_lvl_r)),
    .hit   (wake_hit)
  );

  // Filtered level only moves while wake monitoring is live.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wake_lvl_r <= 1'b0;
    end else if (wake_hit) begin
      wake_lvl_r <= ~wake_lvl_r;
    end
  end

  assign wake_edge = wake_hit && (blank_cnt_r == '0);

  // -------------------------------------------------------------------
  // Switch diagnosis
  // -------------------------------------------------------------------
  persist_filter #(.N(hv_pkg::OC_FILT_CYC)) u_oc_filt (
    .mclk  (mclk),
    .rst_b (rst_b),
    .cond  ((ls_switch_on || hs_switch_on) && sync2_r[1]),
    .hit   (oc_hit)
  );

  persist_filter #(.N(OL_FILT_CYC)) u_ol_filt (
    .mclk  (mclk),
    .rst_b (rst_b),
    .cond  (hs_switch_on && func_r == hv_pkg::FUNC_HS && sync2_r[2]),
    .hit   (ol_hit)
  );

  // -------------------------------------------------------------------
  // Mode sequencer
  // -------------------------------------------------------------------
  assign sleep_refused = wr_mode && pwdata[1:0] == hv_pkg::REQ_SLEEP && meas_r && !oth_r &&
                         (mode_r == hv_pkg::M_NORMAL || mode_r == hv_pkg::M_STOP);

  // Next mode from software requests, wake edges and the fail-safe request.
  always_comb begin
    mode_nxt = mode_r;
    if (sync2_r[3]) begin
      mode_nxt = hv_pkg::M_FAILSAFE;
    end else begin
      unique case (mode_r)
        hv_pkg::M_NORMAL, hv_pkg::M_STOP: begin
          if (sleep_refused) begin
            mode_nxt = hv_pkg::M_RESTART;
          end else if (wr_mode && pwdata[1:0] == hv_pkg::REQ_SLEEP) begin
            mode_nxt = hv_pkg::M_SLEEP;
          end else if (wr_mode && pwdata[1:0] == hv_pkg::REQ_STOP) begin
            mode_nxt = hv_pkg::M_STOP;
          end else if (wr_mode && pwdata[1:0] == hv_pkg::REQ_NORMAL) begin
            mode_nxt = hv_pkg::M_NORMAL;
          end
        end
        hv_pkg::M_SLEEP: begin
          if (wake_edge) begin
            mode_nxt = hv_pkg::M_NORMAL;
          end
        end
        hv_pkg::M_RESTART: begin
          mode_nxt = hv_pkg::M_NORMAL;
        end
        hv_pkg::M_FAILSAFE: begin
          if (wake_edge) begin
            mode_nxt = hv_pkg::M_RESTART;
          end
        end
        default: mode_nxt = hv_pkg::M_RESTART;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode_r <= hv_pkg::M_NORMAL;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // -------------------------------------------------------------------
  // Events and outputs
  // -------------------------------------------------------------------
  assign ev.set[hv_pkg::EV_WAKE] = wake_edge;
  assign ev.set[hv_pkg::EV_OC]   = oc_hit;
  assign ev.set[hv_pkg::EV_OL]   = ol_hit;
  assign ev.set[hv_pkg::EV_ERR]  = err_ev;
  assign ev.clr      = (wr && paddr == hv_pkg::ADDR_CLR) ? pwdata[hv_pkg::EV_W-1:0] : '0;
  assign ev.en_we    = wr && (paddr == hv_pkg::ADDR_EN);
  assign ev.en_wdata = pwdata[hv_pkg::EV_W-1:0];

  irq_events u_irq (
    .mclk  (mclk),
    .rst_b (rst_b),
    .bus   (ev.blk)
  );

  // The interrupt pin only reports in Normal and Stop.
  assign irq             = ev.irq;
  assign interrupt_out_n = !(ev.irq && (mode_r == hv_pkg::M_NORMAL || mode_r == hv_pkg::M_STOP));
  // Sensing blocks every pin function and enables the routing path.
  assign measure_route_en = meas_r;
  assign fail_output_on   = !meas_r && func_r == hv_pkg::FUNC_FO &&
                            (test_r || mode_r == hv_pkg::M_RESTART || mode_r == hv_pkg::M_FAILSAFE);
  assign ls_switch_on     = !meas_r && func_r == hv_pkg::FUNC_LS;
  assign hs_switch_on     = !meas_r && (func_r == hv_pkg::FUNC_HS || func_r == hv_pkg::FUNC_HSCS);
  assign pull_up_en       = !meas_r && pull_r[hv_pkg::PULL_UP];
  assign pull_down_en     = !meas_r && pull_r[hv_pkg::PULL_DN];
  assign sbc_mode         = mode_r;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_sleep_req;
    mode_r == hv_pkg::M_NORMAL && wr_mode && pwdata[1:0] == hv_pkg::REQ_SLEEP;
  endsequence

  a_meas_blocks_pin: assert property (meas_r |-> measure_route_en && !fail_output_on &&
    !ls_switch_on && !hs_switch_on) else $error("pin function active during sensing");
  a_enable_err: assert property (wr_ctrl && meas_r && new_func != hv_pkg::FUNC_OFF &&
    new_func != func_r && !oc_hit |=> ev.status[hv_pkg::EV_ERR] && $stable(func_r))
    else $error("enable attempt during sensing not flagged");
  a_meas_no_pull: assert property (meas_r |-> !pull_up_en && !pull_down_en)
    else $error("pull source active during sensing");
  a_pull_stored: assert property (wr_ctrl |=> pull_r == $past(pwdata[6:5]))
    else $error("pull setting not stored");
  a_meas_refused: assert property (wr_ctrl && !meas_r && pwdata[hv_pkg::CTRL_MEAS] &&
    new_func == hv_pkg::FUNC_FO |=> !meas_r && ev.status[hv_pkg::EV_ERR])
    else $error("sensing enabled over fail output");
  a_level_frozen: assert property (meas_r |=> $stable(wake_lvl_r) &&
    !ev.set[hv_pkg::EV_WAKE]) else $error("wake status moved during sensing");
  a_sleep_refused: assert property (s_sleep_req ##0 (meas_r && !oth_r && !sync2_r[3])
    |=> mode_r == hv_pkg::M_RESTART && ev.status[hv_pkg::EV_ERR])
    else $error("sleep entered with sensed pin as sole wake source");
  a_blank_window: assert property ($rose(wake_en) |=> blank_cnt_r != '0 ##0
    (!wake_edge) [*8]) else $error("wake edge inside blanking window");
  a_oc_shutdown: assert property (oc_hit |=> func_r == hv_pkg::FUNC_OFF &&
    !ls_switch_on && !hs_switch_on && ev.status[hv_pkg::EV_OC])
    else $error("switch not shut down on overcurrent");
  a_wake_irq: assert property (wake_edge && mode_r == hv_pkg::M_NORMAL && !sync2_r[3] &&
    ev.en[hv_pkg::EV_WAKE] |=> !interrupt_out_n) else $error("wake edge raised no interrupt");
endmodule
`default_nettype wire

// >>> verification/pin_load_model.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// External load and wake source on the high-voltage pin
// ---------------------------------------------------------------
module pin_load_model (
  input  wire logic ls_switch_on,
  input  wire logic hs_switch_on,
  input  wire logic wake_level,
  input  wire logic short_fault,
  input  wire logic open_fault,
  output logic      hv_wake_pin,
  output logic      overcurrent_det,
  output logic      open_load_det
);
  // The comparator follows the level that the outside source applies.
  assign hv_wake_pin     = wake_level;
  // A shorted load only draws excess current while a switch conducts.
  assign overcurrent_det = short_fault & (ls_switch_on | hs_switch_on);
  // A missing load only shows while the high-side switch is on.
  assign open_load_det   = open_fault & hs_switch_on;
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Bench for the pin interlock block
// ---------------------------------------------------------------
module tb_top;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hv_wake_pin;
  logic        oc_det;
  logic        ol_det;
  logic        fail_safe_req = 1'b0;
  logic        irq;
  logic        interrupt_out_n;
  logic        fail_output_on;
  logic        ls_on;
  logic        hs_on;
  logic        pu_en;
  logic        pd_en;
  logic        route_en;
  logic [2:0]  sbc_mode;
  logic        wake_lvl = 1'b0;
  logic        short_f = 1'b0;
  logic        open_f = 1'b0;
  logic        saw_restart = 1'b0;
  logic [31:0] rd;
  logic        rd_err;
  int          failures = 0;
  int          checked = 0;

  // The clock toggles every half period of 5 ns.
  always #5 mclk = ~mclk;

  // The open-load filter is shortened to keep the run brief.
  hv_pin_measure_interlock #(.OL_FILT_CYC(8)) hv_pin_measure_interlock_i (
    .mclk(mclk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hv_wake_pin(hv_wake_pin), .overcurrent_det(oc_det),
    .open_load_det(ol_det), .fail_safe_req(fail_safe_req), .irq(irq),
    .interrupt_out_n(interrupt_out_n), .fail_output_on(fail_output_on),
    .ls_switch_on(ls_on), .hs_switch_on(hs_on), .pull_up_en(pu_en),
    .pull_down_en(pd_en), .measure_route_en(route_en), .sbc_mode(sbc_mode));

  pin_load_model pin_load_model_i (
    .ls_switch_on(ls_on), .hs_switch_on(hs_on), .wake_level(wake_lvl),
    .short_fault(short_f), .open_fault(open_f), .hv_wake_pin(hv_wake_pin),
    .overcurrent_det(oc_det), .open_load_det(ol_det));

  // The one-cycle Restart pass is caught here since no read can see it.
  always @(posedge mclk) begin
    if (sbc_mode === 3'h3) begin
      saw_restart <= 1'b1;
    end
  end

  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Writes a register, then lets one edge pass so that outputs have settled.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge mclk);
  endtask

  // Reads a register and compares the masked bits.
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd & m, e);
  endtask

  // Waits a number of clock edges.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Watchdog that cuts a hung run short.
  initial begin
    tick(40000);
    failures++;
    tally_and_finish();
  end

  // Main test sequence.
  initial begin
    tick(16);
    rst_b <= 1'b1;
    rdm(hv_pkg::ADDR_CTRL, 32'hFFFF_FFFF, hv_pkg::CTRL_RST);
    rdm(hv_pkg::ADDR_MODE, 32'h0000_0007, 32'h0000_0000);
    rdm(hv_pkg::ADDR_STAT, 32'h0000_000F, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    check(32'(rd_err), 32'h0000_0001);
    // Sensing is refused while the pin is the fail output.
    wr(hv_pkg::ADDR_CTRL, 32'h0000_0008);
    rdm(hv_pkg::ADDR_CTRL, 32'h0000_00FF, 32'h0000_0000);
    rdm(hv_pkg::ADDR_STAT, 32'h0000_0008, 32'h0000_0008);
    wr(hv_pkg::ADDR_CLR, 32'h0000_000F);
    wr(hv_pkg::ADDR_CTRL, 32'h0000_0010);
    check(32'(fail_output_on), 32'h0000_0001);
    // Sensing from Off, then forbidden function and test writes.
    wr(hv_pkg::ADDR_CTRL, 32'h0000_0004);
    wr(hv_pkg::ADDR_CTRL, 32'h0000_000C);
    check(32'(route_en), 32'h0000_0001);
    wr(hv_pkg::ADDR_CTRL, 32'h0000_000D);
    rdm(hv_pkg::ADDR_CTRL, 32'h0000_0007, 32'h0000_0004);
    rdm(hv_pkg::ADDR_STAT, 32'h0000_0008, 32'h0000_0008);
    wr(hv_pkg::ADDR_CLR, 32'h0000_0008);
    wr(hv_pkg::ADDR_CTRL, 32'h0000_001C);
    check(32'(fail_output_on), 32'h0000_0000);
    rdm(hv_pkg::ADDR_STAT, 32'h0000_0008, 32'h0000_0008);
    wr(hv_pkg::ADDR_CLR, 32'h0000_0008);
    wr(hv_pkg::ADDR_CTRL, 32'h0000_006C);
    rdm(hv_pkg::ADDR_CTRL, 32'h0000_0068, 32'h0000_0068);
    check(32'({pu_en, pd_en}), 32'h0000_0000);
    // Sleep with the sensed pin as the only wake source.
    wr(hv_pkg::ADDR_MODE, 32'(hv_pkg::REQ_SLEEP));
    tick(4);
    check(32'(saw_restart), 32'h0000_0001);
    check(32'(sbc_mode), 32'h0000_0000);
    rdm(hv_pkg::ADDR_STAT, 32'h0000_0008, 32'h0000_0008);
    wr(hv_pkg::ADDR_MODE, 32'(hv_pkg::REQ_STOP));
    check(32'(sbc_mode), 32'h0000_0001);
    wr(hv_pkg::ADDR_MODE, 32'(hv_pkg::REQ_NORMAL));
    wr(hv_pkg::ADDR_CLR, 32'h0000_000F);
    // Sensing off first with the function frozen at Off, then the wake input.
    wr(hv_pkg::ADDR_CTRL, 32'h0000_0024);
    wr(hv_pkg::ADDR_CTRL, 32'h0000_0025);
    check(32'({pu_en, pd_en}), 32'h0000_0001);
    wake_lvl <= 1'b1;
    tick(1500);
    rdm(hv_pkg::ADDR_LVL, 32'h0000_0001, 32'h0000_0000);
    tick(200);
    rdm(hv_pkg::ADDR_LVL, 32'h0000_0001, 32'h0000_0001);
    rdm(hv_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_0000);
    tick(1400);
    wake_lvl <= 1'b0;
    tick(1500);
    rdm(hv_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_0000);
    tick(200);
    rdm(hv_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_0001);
    wr(hv_pkg::ADDR_EN, 32'h0000_0001);
    check(32'({irq, interrupt_out_n}), 32'h0000_0002);
    wr(hv_pkg::ADDR_CLR, 32'h0000_0001);
    check(32'({irq, interrupt_out_n}), 32'h0000_0001);
    // Sensing on a wake input freezes level and event.
    wr(hv_pkg::ADDR_CTRL, 32'h0000_002D);
    check(32'({pu_en, pd_en}), 32'h0000_0000);
    wake_lvl <= 1'b1;
    tick(1700);
    rdm(hv_pkg::ADDR_LVL, 32'h0000_0001, 32'h0000_0000);
    rdm(hv_pkg::ADDR_STAT, 32'h0000_0001, 32'h0000_0000);
    // Low-side overcurrent shutdown.
    wr(hv_pkg::ADDR_CTRL, 32'h0000_0004);
    wr(hv_pkg::ADDR_CTRL, 32'h0000_0006);
    short_f <= 1'b1;
    tick(2500);
    check(32'(ls_on), 32'h0000_0001);
    tick(200);
    check(32'(ls_on), 32'h0000_0000);
    rdm(hv_pkg::ADDR_CTRL, 32'h0000_0007, 32'h0000_0004);
    rdm(hv_pkg::ADDR_STAT, 32'h0000_0002, 32'h0000_0002);
    short_f <= 1'b0;
    // High-side open load, then Fail-Safe entry.
    open_f <= 1'b1;
    wr(hv_pkg::ADDR_CTRL, 32'h0000_0007);
    rdm(hv_pkg::ADDR_STAT, 32'h0000_0004, 32'h0000_0000);
    tick(20);
    rdm(hv_pkg::ADDR_STAT, 32'h0000_0004, 32'h0000_0004);
    open_f <= 1'b0;
    fail_safe_req <= 1'b1;
    tick(6);
    check(32'({sbc_mode, hs_on}), 32'h0000_0008);
    rdm(hv_pkg::ADDR_CTRL, 32'h0000_0007, 32'h0000_0004);
    tally_and_finish();
  end
endmodule
`default_nettype wire
